// ### verilog/scg_top.sv
// Chosen here: the placing of the registers and register access over AXI4-Lite.
module scg_top
	import scg_pkg::*;
(
	input wire logic clk_sys_in,
	input wire logic nrst_in,
	input wire logic [31:0] s_axi_awaddr_in,
	input wire logic s_axi_awvalid_in,
	output logic s_axi_awready_out,
	input wire logic [31:0] s_axi_wdata_in,
	input wire logic [3:0] s_axi_wstrb_in,
	input wire logic s_axi_wvalid_in,
	output logic s_axi_wready_out,
	output logic [1:0] s_axi_bresp_out,
	output logic s_axi_bvalid_out,
	input wire logic s_axi_bready_in,
	input wire logic [31:0] s_axi_araddr_in,
	input wire logic s_axi_arvalid_in,
	output logic s_axi_arready_out,
	output logic [31:0] s_axi_rdata_out,
	output logic [1:0] s_axi_rresp_out,
	output logic s_axi_rvalid_out,
	input wire logic s_axi_rready_in,
	input wire logic sclk_pin_in,
	output logic sclk_pin_out,
	output logic sclk_pin_oe_out,
	input wire logic rx_restart_in,
	output logic serial_transfer_clock_out,
	output logic io_shift_tick_out,
	output logic uart_tx_bit_tick_out,
	output logic uart_rx_bit_tick_out,
	output logic uart_rx_sample_out
);
	// ==========================================
	// registers
	logic [3:0] mode0_reg, mode0_next;
	logic [1:0] ctrl_reg, ctrl_next;
	logic [6:0] baud_reg, baud_next;
	logic [3:0] frac_reg, frac_next;
	logic [15:0] tcmp_reg, tcmp_next;
	logic aw_full_reg, aw_full_next;
	logic w_full_reg, w_full_next;
	logic [7:0] aw_addr_reg, aw_addr_next;
	logic [31:0] w_data_reg, w_data_next;
	logic [3:0] w_strb_reg, w_strb_next;
	logic bvalid_reg, bvalid_next;
	logic [1:0] bresp_reg, bresp_next;
	logic rvalid_reg, rvalid_next;
	logic [1:0] rresp_reg, rresp_next;
	logic [31:0] rdata_reg, rdata_next;
	logic awready_reg, awready_next;
	logic wready_reg, wready_next;
	logic arready_reg, arready_next;
	logic oe_reg, oe_next;
	logic [31:0] wr_word;

	logic [1:0] serial_mode_select;
	logic [1:0] uart_clock_source_select;
	logic [1:0] baud_input_select;
	logic io_clock_is_input;
	logic io_falling_edge;
	logic is_uart;

	assign serial_mode_select = mode0_reg[SCG_SM_LSB +: 2];
	assign uart_clock_source_select = mode0_reg[SCG_SC_LSB +: 2];
	assign baud_input_select = baud_reg[SCG_BAUD_INPUT_SELECT_LSB +: 2];
	assign io_clock_is_input = ctrl_reg[SCG_IOC_BIT];
	assign io_falling_edge = ctrl_reg[SCG_SCLKS_BIT];
	assign is_uart = (serial_mode_select != SCG_SM_IO);

	function automatic logic [31:0] merge_bytes(input logic [31:0] old, input logic [31:0] data,
			input logic [3:0] strb);
		logic [31:0] r;
		r = old;
		for (int i = 0; i < 4; i++) begin
			if (strb[i]) begin
				r[8*i +: 8] = data[8*i +: 8];
			end
		end
		return r;
	endfunction

	// ==========================================
	// clock sources
	logic [6:0] pre_reg, pre_next;
	logic [15:0] tcnt_reg, tcnt_next;
	logic tff_reg, tff_next;
	logic pin_s1_reg, pin_s2_reg, pin_s3_reg;
	logic tap_tick;
	logic gen_tick;
	logic pin_rise, pin_fall;

	always_comb begin
		pre_next = pre_reg + 7'h01;
		tcnt_next = tcnt_reg;
		tff_next = tff_reg;
		// timer counts on the fastest tap, flop inverts after compare taps
		if (pre_reg[0]) begin
			if ({1'b0, tcnt_reg} + 17'h00001 >= {1'b0, tcmp_reg}) begin
				tcnt_next = 16'h0000;
				tff_next = !tff_reg;
			end else begin
				tcnt_next = tcnt_reg + 16'h0001;
			end
		end
		unique case (baud_input_select)
			SCG_BAUD_INPUT_SELECT_DIV2: tap_tick = pre_reg[0];
			SCG_BAUD_INPUT_SELECT_DIV8: tap_tick = &pre_reg[2:0];
			SCG_BAUD_INPUT_SELECT_DIV32: tap_tick = &pre_reg[4:0];
			SCG_BAUD_INPUT_SELECT_DIV128: tap_tick = &pre_reg[6:0];
		endcase
	end

	always_ff @(posedge clk_sys_in or negedge nrst_in) begin
		if (!nrst_in) begin
			pre_reg <= 7'h00;
			tcnt_reg <= 16'h0000;
			tff_reg <= 1'b0;
			pin_s1_reg <= 1'b0;
			pin_s2_reg <= 1'b0;
			pin_s3_reg <= 1'b0;
		end else begin
			pre_reg <= pre_next;
			tcnt_reg <= tcnt_next;
			tff_reg <= tff_next;
			pin_s1_reg <= sclk_pin_in;
			pin_s2_reg <= pin_s1_reg;
			pin_s3_reg <= pin_s2_reg;
		end
	end

	// the pin is only trusted when slower than two system clocks
	assign pin_rise = pin_s2_reg && !pin_s3_reg;
	assign pin_fall = !pin_s2_reg && pin_s3_reg;

	// fraction is ignored outside UART so I/O mode stays integer
	scg_baud_gen u_baud_gen (
		.clk_sys_in(clk_sys_in),
		.nrst_in(nrst_in),
		.tick_in(tap_tick),
		.div_n_in(baud_reg[SCG_BRS_LSB +: 4]),
		.frac_en_in(is_uart && baud_reg[SCG_BRADDE_BIT]),
		.frac_k_in(frac_reg),
		.tick_out(gen_tick)
	);

	// ==========================================
	// clock selection and bit counters
	logic tff_prev_reg;
	logic sclk_reg, sclk_next;
	logic serial_transfer_clock_reg, serial_transfer_clock_next;
	logic shift_reg, shift_next;
	logic [3:0] rxcnt_reg, rxcnt_next;
	logic [3:0] txcnt_reg, txcnt_next;
	logic rxbit_reg, rxbit_next;
	logic txbit_reg, txbit_next;
	logic sample_reg, sample_next;
	logic sel_tick;

	always_comb begin
		sclk_next = sclk_reg;
		shift_next = 1'b0;
		sel_tick = 1'b0;
		if (is_uart) begin
			sclk_next = 1'b1;
			unique case (uart_clock_source_select)
				SCG_SC_TIMER: sel_tick = tff_reg && !tff_prev_reg;
				SCG_SC_BAUD: sel_tick = gen_tick;
				SCG_SC_FSYS: sel_tick = 1'b1;
				SCG_SC_PIN: sel_tick = pin_rise;
			endcase
		end else if (io_clock_is_input) begin
			sclk_next = 1'b1;
			sel_tick = io_falling_edge ? pin_fall : pin_rise;
			shift_next = sel_tick;
		end else begin
			// pin toggles per generator tick, shifting on its rising edge
			if (gen_tick) begin
				sclk_next = !sclk_reg;
				sel_tick = !sclk_reg;
			end
			shift_next = sel_tick;
		end
		serial_transfer_clock_next = sel_tick;
		rxcnt_next = rxcnt_reg;
		txcnt_next = txcnt_reg;
		rxbit_next = 1'b0;
		txbit_next = 1'b0;
		sample_next = 1'b0;
		if (!is_uart || rx_restart_in) begin
			rxcnt_next = 4'h0;
		end else if (sel_tick) begin
			rxcnt_next = rxcnt_reg + 4'h1;
			rxbit_next = (rxcnt_reg == SCG_OVERSAMPLE_LAST);
			sample_next = (rxcnt_reg >= SCG_SAMPLE_FIRST) && (rxcnt_reg <= SCG_SAMPLE_LAST);
		end
		if (!is_uart) begin
			txcnt_next = 4'h0;
		end else if (sel_tick) begin
			txcnt_next = txcnt_reg + 4'h1;
			txbit_next = (txcnt_reg == SCG_OVERSAMPLE_LAST);
		end
	end

	always_ff @(posedge clk_sys_in or negedge nrst_in) begin
		if (!nrst_in) begin
			tff_prev_reg <= 1'b0;
			sclk_reg <= 1'b1;
			serial_transfer_clock_reg <= 1'b0;
			shift_reg <= 1'b0;
			rxcnt_reg <= 4'h0;
			txcnt_reg <= 4'h0;
			rxbit_reg <= 1'b0;
			txbit_reg <= 1'b0;
			sample_reg <= 1'b0;
		end else begin
			tff_prev_reg <= tff_reg;
			sclk_reg <= sclk_next;
			serial_transfer_clock_reg <= serial_transfer_clock_next;
			shift_reg <= shift_next;
			rxcnt_reg <= rxcnt_next;
			txcnt_reg <= txcnt_next;
			rxbit_reg <= rxbit_next;
			txbit_reg <= txbit_next;
			sample_reg <= sample_next;
		end
	end

	// ==========================================
	// register bus slave
	always_comb begin
		mode0_next = mode0_reg;
		ctrl_next = ctrl_reg;
		baud_next = baud_reg;
		frac_next = frac_reg;
		tcmp_next = tcmp_reg;
		aw_full_next = aw_full_reg;
		w_full_next = w_full_reg;
		aw_addr_next = aw_addr_reg;
		w_data_next = w_data_reg;
		w_strb_next = w_strb_reg;
		bvalid_next = bvalid_reg;
		bresp_next = bresp_reg;
		rvalid_next = rvalid_reg;
		rresp_next = rresp_reg;
		rdata_next = rdata_reg;
		wr_word = 32'h0000_0000;
		if (s_axi_awvalid_in && awready_reg) begin
			aw_full_next = 1'b1;
			aw_addr_next = s_axi_awaddr_in[7:0];
		end
		if (s_axi_wvalid_in && wready_reg) begin
			w_full_next = 1'b1;
			w_data_next = s_axi_wdata_in;
			w_strb_next = s_axi_wstrb_in;
		end
		if (bvalid_reg && s_axi_bready_in) begin
			bvalid_next = 1'b0;
		end
		if (aw_full_reg && w_full_reg && !bvalid_reg) begin
			aw_full_next = 1'b0;
			w_full_next = 1'b0;
			bvalid_next = 1'b1;
			bresp_next = SCG_RESP_OKAY;
			unique case (aw_addr_reg)
				SCG_MODE0_OFF: begin
					wr_word = merge_bytes({28'h0, mode0_reg}, w_data_reg, w_strb_reg);
					mode0_next = wr_word[3:0];
				end
				SCG_CTRL_OFF: begin
					wr_word = merge_bytes({30'h0, ctrl_reg}, w_data_reg, w_strb_reg);
					ctrl_next = wr_word[1:0];
					// edge select is held at rising while the pin is an output
					if (!wr_word[SCG_IOC_BIT]) begin
						ctrl_next[SCG_SCLKS_BIT] = 1'b0;
					end
				end
				SCG_BAUD_OFF: begin
					// divisor 1 is accepted; its legality rests with software
					wr_word = merge_bytes({25'h0, baud_reg}, w_data_reg, w_strb_reg);
					baud_next = wr_word[6:0];
				end
				SCG_FRAC_OFF: begin
					wr_word = merge_bytes({28'h0, frac_reg}, w_data_reg, w_strb_reg);
					frac_next = wr_word[3:0];
				end
				SCG_TCMP_OFF: begin
					wr_word = merge_bytes({16'h0, tcmp_reg}, w_data_reg, w_strb_reg);
					tcmp_next = wr_word[15:0];
				end
				default: bresp_next = SCG_RESP_SLVERR;
			endcase
		end
		if (rvalid_reg && s_axi_rready_in) begin
			rvalid_next = 1'b0;
		end
		if (s_axi_arvalid_in && arready_reg) begin
			rvalid_next = 1'b1;
			rresp_next = SCG_RESP_OKAY;
			unique case (s_axi_araddr_in[7:0])
				SCG_MODE0_OFF: rdata_next = {28'h0, mode0_reg};
				SCG_CTRL_OFF: rdata_next = {30'h0, ctrl_reg};
				SCG_BAUD_OFF: rdata_next = {25'h0, baud_reg};
				SCG_FRAC_OFF: rdata_next = {28'h0, frac_reg};
				SCG_TCMP_OFF: rdata_next = {16'h0, tcmp_reg};
				SCG_STAT_OFF: rdata_next = {21'h0, rxcnt_reg, txcnt_reg, pin_s2_reg, tff_reg, sclk_reg};
				default: begin
					rdata_next = 32'h0000_0000;
					rresp_next = SCG_RESP_SLVERR;
				end
			endcase
		end
		// registered from the next register values so the drive follows the write at once
		oe_next = (mode0_next[SCG_SM_LSB +: 2] == SCG_SM_IO) && !ctrl_next[SCG_IOC_BIT];
		awready_next = !aw_full_next;
		wready_next = !w_full_next;
		arready_next = !rvalid_next;
	end

	always_ff @(posedge clk_sys_in or negedge nrst_in) begin
		if (!nrst_in) begin
			mode0_reg <= SCG_MODE0_RST;
			ctrl_reg <= SCG_CTRL_RST;
			baud_reg <= SCG_BAUD_RST;
			frac_reg <= SCG_FRAC_RST;
			tcmp_reg <= SCG_TCMP_RST;
			aw_full_reg <= 1'b0;
			w_full_reg <= 1'b0;
			aw_addr_reg <= 8'h00;
			w_data_reg <= 32'h0000_0000;
			w_strb_reg <= 4'h0;
			bvalid_reg <= 1'b0;
			bresp_reg <= 2'h0;
			rvalid_reg <= 1'b0;
			rresp_reg <= 2'h0;
			rdata_reg <= 32'h0000_0000;
			awready_reg <= 1'b0;
			wready_reg <= 1'b0;
			arready_reg <= 1'b0;
			oe_reg <= 1'b1;
		end else begin
			mode0_reg <= mode0_next;
			ctrl_reg <= ctrl_next;
			baud_reg <= baud_next;
			frac_reg <= frac_next;
			tcmp_reg <= tcmp_next;
			aw_full_reg <= aw_full_next;
			w_full_reg <= w_full_next;
			aw_addr_reg <= aw_addr_next;
			w_data_reg <= w_data_next;
			w_strb_reg <= w_strb_next;
			bvalid_reg <= bvalid_next;
			bresp_reg <= bresp_next;
			rvalid_reg <= rvalid_next;
			rresp_reg <= rresp_next;
			rdata_reg <= rdata_next;
			awready_reg <= awready_next;
			wready_reg <= wready_next;
			arready_reg <= arready_next;
			oe_reg <= oe_next;
		end
	end

	assign s_axi_awready_out = awready_reg;
	assign s_axi_wready_out = wready_reg;
	assign s_axi_bvalid_out = bvalid_reg;
	assign s_axi_bresp_out = bresp_reg;
	assign s_axi_arready_out = arready_reg;
	assign s_axi_rvalid_out = rvalid_reg;
	assign s_axi_rresp_out = rresp_reg;
	assign s_axi_rdata_out = rdata_reg;
	assign sclk_pin_out = sclk_reg;
	assign sclk_pin_oe_out = oe_reg;
	assign serial_transfer_clock_out = serial_transfer_clock_reg;
	assign io_shift_tick_out = shift_reg;
	assign uart_tx_bit_tick_out = txbit_reg;
	assign uart_rx_bit_tick_out = rxbit_reg;
	assign uart_rx_sample_out = sample_reg;
endmodule // scg_top

// ### verilog/scg_pkg.sv
package scg_pkg;
	// ==========================================
	// register map (byte addresses, one word each)
	localparam logic [7:0] SCG_MODE0_OFF = 8'h00;
	localparam logic [7:0] SCG_CTRL_OFF = 8'h04;
	localparam logic [7:0] SCG_BAUD_OFF = 8'h08;
	localparam logic [7:0] SCG_FRAC_OFF = 8'h0c;
	localparam logic [7:0] SCG_TCMP_OFF = 8'h10;
	localparam logic [7:0] SCG_STAT_OFF = 8'h14;

	// ==========================================
	// field positions
	localparam int SCG_SM_LSB = 0;
	localparam int SCG_SC_LSB = 2;
	localparam int SCG_IOC_BIT = 0;
	localparam int SCG_SCLKS_BIT = 1;
	localparam int SCG_BRS_LSB = 0;
	localparam int SCG_BAUD_INPUT_SELECT_LSB = 4;
	localparam int SCG_BRADDE_BIT = 6;
	localparam int SCG_BRK_LSB = 0;

	// ==========================================
	// field codes
	localparam logic [1:0] SCG_SM_IO = 2'h0;
	localparam logic [1:0] SCG_SC_TIMER = 2'h0;
	localparam logic [1:0] SCG_SC_BAUD = 2'h1;
	localparam logic [1:0] SCG_SC_FSYS = 2'h2;
	localparam logic [1:0] SCG_SC_PIN = 2'h3;
	localparam logic [1:0] SCG_BAUD_INPUT_SELECT_DIV2 = 2'h0;
	localparam logic [1:0] SCG_BAUD_INPUT_SELECT_DIV8 = 2'h1;
	localparam logic [1:0] SCG_BAUD_INPUT_SELECT_DIV32 = 2'h2;
	localparam logic [1:0] SCG_BAUD_INPUT_SELECT_DIV128 = 2'h3;

	// ==========================================
	// reset values
	localparam logic [3:0] SCG_MODE0_RST = 4'h0;
	localparam logic [1:0] SCG_CTRL_RST = 2'h0;
	localparam logic [6:0] SCG_BAUD_RST = 7'h00;
	localparam logic [3:0] SCG_FRAC_RST = 4'h0;
	localparam logic [15:0] SCG_TCMP_RST = 16'h0000;

	// ==========================================
	// counts and bus response codes
	localparam logic [3:0] SCG_OVERSAMPLE_LAST = 4'hf;
	localparam logic [3:0] SCG_SAMPLE_FIRST = 4'h6;
	localparam logic [3:0] SCG_SAMPLE_LAST = 4'h8;
	localparam logic [1:0] SCG_RESP_OKAY = 2'h0;
	localparam logic [1:0] SCG_RESP_SLVERR = 2'h2;
endpackage

// ### verilog/scg_baud_gen.sv
// divides input ticks by n, or by n + (16-k)/16 when frac_en_in is set
module scg_baud_gen
	import scg_pkg::*;
(
	input wire logic clk_sys_in,
	input wire logic nrst_in,
	input wire logic tick_in,
	input wire logic [3:0] div_n_in,
	input wire logic frac_en_in,
	input wire logic [3:0] frac_k_in,
	output logic tick_out
);
	logic [4:0] cnt_reg, cnt_next;
	logic [3:0] acc_reg, acc_next;
	logic stretch_reg, stretch_next;
	logic tick_reg, tick_next;
	logic [4:0] period;
	logic [4:0] acc_sum;

	// ==========================================
	// period control
	always_comb begin
		// field value 0 stands for 16
		period = (div_n_in == 4'h0) ? 5'h10 : {1'b0, div_n_in};
		if (stretch_reg) begin
			period = period + 5'h01;
		end
		acc_sum = {1'b0, acc_reg} + (5'h10 - {1'b0, frac_k_in});
		cnt_next = cnt_reg;
		acc_next = acc_reg;
		stretch_next = stretch_reg;
		tick_next = 1'b0;
		if (tick_in) begin
			if (cnt_reg + 5'h01 >= period) begin
				cnt_next = 5'h00;
				tick_next = 1'b1;
				// carry of the accumulator spreads 16-k long periods evenly over 16
				if (frac_en_in) begin
					acc_next = acc_sum[3:0];
					stretch_next = acc_sum[4];
				end else begin
					acc_next = 4'h0;
					stretch_next = 1'b0;
				end
			end else begin
				cnt_next = cnt_reg + 5'h01;
			end
		end
	end

	always_ff @(posedge clk_sys_in or negedge nrst_in) begin
		if (!nrst_in) begin
			cnt_reg <= 5'h00;
			acc_reg <= 4'h0;
			stretch_reg <= 1'b0;
			tick_reg <= 1'b0;
		end else begin
			cnt_reg <= cnt_next;
			acc_reg <= acc_next;
			stretch_reg <= stretch_next;
			tick_reg <= tick_next;
		end
	end

	assign tick_out = tick_reg;
endmodule // scg_baud_gen

// ### dv/scg_top_assertions.sv
// ==========================================
// bus handshake and serial clock relations seen at the top ports
module scg_checker
	import scg_pkg::*;
(
	input wire logic clk_sys_in,
	input wire logic nrst_in,
	input wire logic s_axi_awvalid_in,
	input wire logic s_axi_awready_out,
	input wire logic s_axi_wvalid_in,
	input wire logic s_axi_wready_out,
	input wire logic [1:0] s_axi_bresp_out,
	input wire logic s_axi_bvalid_out,
	input wire logic s_axi_bready_in,
	input wire logic s_axi_arvalid_in,
	input wire logic s_axi_arready_out,
	input wire logic [31:0] s_axi_rdata_out,
	input wire logic s_axi_rvalid_out,
	input wire logic s_axi_rready_in,
	input wire logic sclk_pin_in,
	input wire logic sclk_pin_out,
	input wire logic sclk_pin_oe_out,
	input wire logic rx_restart_in,
	input wire logic serial_transfer_clock_out,
	input wire logic io_shift_tick_out,
	input wire logic uart_tx_bit_tick_out,
	input wire logic uart_rx_bit_tick_out
);
	default clocking cb @(posedge clk_sys_in);
	endclocking
	default disable iff (!nrst_in);

	// ==========================================
	// serial ticks since the last bit tick; any I/O activity voids the count
	logic [5:0] tx_cnt_reg, tx_cnt_next, rx_cnt_reg, rx_cnt_next;
	logic tx_seen_reg, tx_seen_next, rx_seen_reg, rx_seen_next;
	logic io_busy;
	always_comb begin
		io_busy = io_shift_tick_out | sclk_pin_oe_out;
		tx_cnt_next = uart_tx_bit_tick_out ? 6'(serial_transfer_clock_out) : tx_cnt_reg + 6'(serial_transfer_clock_out);
		rx_cnt_next = uart_rx_bit_tick_out ? 6'(serial_transfer_clock_out) : rx_cnt_reg + 6'(serial_transfer_clock_out);
		tx_seen_next = (tx_seen_reg | uart_tx_bit_tick_out) & ~io_busy;
		rx_seen_next = (rx_seen_reg | uart_rx_bit_tick_out) & ~io_busy & ~rx_restart_in;
	end
	always_ff @(posedge clk_sys_in or negedge nrst_in) begin
		if (!nrst_in) begin
			tx_cnt_reg <= 6'h00;
			rx_cnt_reg <= 6'h00;
			tx_seen_reg <= 1'b0;
			rx_seen_reg <= 1'b0;
		end else begin
			tx_cnt_reg <= tx_cnt_next;
			rx_cnt_reg <= rx_cnt_next;
			tx_seen_reg <= tx_seen_next;
			rx_seen_reg <= rx_seen_next;
		end
	end

	a_bresp_holds: assert property (s_axi_bvalid_out && !s_axi_bready_in |=> s_axi_bvalid_out && $stable(s_axi_bresp_out))
		else $error("write response dropped or changed before acceptance");
	a_rdata_holds: assert property (s_axi_rvalid_out && !s_axi_rready_in |=> s_axi_rvalid_out && $stable(s_axi_rdata_out))
		else $error("read data dropped or changed before acceptance");
	a_write_answer_time: assert property (s_axi_awvalid_in && s_axi_awready_out && s_axi_wvalid_in && s_axi_wready_out
		|-> ##2 s_axi_bvalid_out) else $error("write response late");
	a_read_answer_time: assert property (s_axi_arvalid_in && s_axi_arready_out |=> s_axi_rvalid_out)
		else $error("read data late");
	a_read_one_open: assert property (s_axi_rvalid_out |-> !s_axi_arready_out)
		else $error("read address accepted while data pending");
	a_out_shift_rising: assert property (io_shift_tick_out && sclk_pin_oe_out |-> sclk_pin_out)
		else $error("driven clock shift not on its rising half");
	a_in_shift_edge: assert property (io_shift_tick_out && !sclk_pin_oe_out |-> $past(sclk_pin_in, 3) != $past(sclk_pin_in, 6))
		else $error("input clock shift without a pin edge");
	a_tx_sixteen: assert property (uart_tx_bit_tick_out && tx_seen_reg |-> tx_cnt_reg == 6'h10)
		else $error("transmit bit not sixteen serial ticks");
	a_rx_sixteen: assert property (uart_rx_bit_tick_out && rx_seen_reg |-> rx_cnt_reg == 6'h10)
		else $error("receive bit not sixteen serial ticks");

	c_write: cover property (s_axi_bvalid_out && s_axi_bready_in);
	c_in_shift: cover property (io_shift_tick_out && !sclk_pin_oe_out);
	c_tx_bit: cover property (uart_tx_bit_tick_out && tx_seen_reg);
endmodule // scg_checker

bind scg_top scg_checker chk_u (.clk_sys_in, .nrst_in, .s_axi_awvalid_in, .s_axi_awready_out, .s_axi_wvalid_in,
	.s_axi_wready_out, .s_axi_bresp_out, .s_axi_bvalid_out, .s_axi_bready_in, .s_axi_arvalid_in, .s_axi_arready_out,
	.s_axi_rdata_out, .s_axi_rvalid_out, .s_axi_rready_in, .sclk_pin_in, .sclk_pin_out, .sclk_pin_oe_out,
	.rx_restart_in, .serial_transfer_clock_out, .io_shift_tick_out, .uart_tx_bit_tick_out, .uart_rx_bit_tick_out);

// ### dv/scg_ext_clock.sv
// ==========================================
// far-side clock source: toggles only inside a frame, released otherwise
module scg_ext_clock (
	input wire logic clk_sys_in,
	input wire logic run_in,
	input wire logic [7:0] half_in,
	output logic drive_out,
	output logic en_out
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [7:0] cnt_reg;
	initial begin
		drive_out = 1'b1;
		en_out = 1'b0;
		cnt_reg = 8'h01;
	end
	// half period never under two system cycles keeps the pin period legal
	always @(posedge clk_sys_in) begin
		en_out <= run_in;
		cnt_reg <= cnt_reg + 8'h01;
		if (!run_in) begin
			cnt_reg <= 8'h01;
			drive_out <= 1'b1;
		end else if (cnt_reg >= half_in && cnt_reg >= 8'h02) begin
			cnt_reg <= 8'h01;
			drive_out <= ~drive_out;
		end
	end
endmodule // scg_ext_clock

// ### dv/scg_top_tb_top.sv
module scg_top_tb_top
	import scg_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;
	logic clk_sys_in, nrst_in, s_axi_awvalid_in, s_axi_wvalid_in, s_axi_bready_in, s_axi_arvalid_in, s_axi_rready_in;
	logic [31:0] s_axi_awaddr_in, s_axi_wdata_in, s_axi_araddr_in, s_axi_rdata_out, rd_data;
	logic [3:0] s_axi_wstrb_in;
	logic s_axi_awready_out, s_axi_wready_out, s_axi_bvalid_out, s_axi_arready_out, s_axi_rvalid_out;
	logic [1:0] s_axi_bresp_out, s_axi_rresp_out, resp;
	logic sclk_pin_out, sclk_pin_oe_out, rx_restart_in, serial_transfer_clock_out, io_shift_tick_out;
	logic uart_tx_bit_tick_out, uart_rx_bit_tick_out, uart_rx_sample_out, ext_run, ext_drive, ext_en;
	logic [7:0] ext_half;
	int failures, num_checks;
	// pull-up holds the line high when nobody drives it
	wire sclk_pin_in = sclk_pin_oe_out ? sclk_pin_out : (ext_en ? ext_drive : 1'b1);

	scg_top dut_u (.clk_sys_in, .nrst_in, .s_axi_awaddr_in, .s_axi_awvalid_in, .s_axi_awready_out, .s_axi_wdata_in,
		.s_axi_wstrb_in, .s_axi_wvalid_in, .s_axi_wready_out, .s_axi_bresp_out, .s_axi_bvalid_out, .s_axi_bready_in,
		.s_axi_araddr_in, .s_axi_arvalid_in, .s_axi_arready_out, .s_axi_rdata_out, .s_axi_rresp_out, .s_axi_rvalid_out,
		.s_axi_rready_in, .sclk_pin_in, .sclk_pin_out, .sclk_pin_oe_out, .rx_restart_in, .serial_transfer_clock_out,
		.io_shift_tick_out, .uart_tx_bit_tick_out, .uart_rx_bit_tick_out, .uart_rx_sample_out);
	scg_ext_clock ext_u (.clk_sys_in, .run_in(ext_run), .half_in(ext_half), .drive_out(ext_drive), .en_out(ext_en));

	initial begin
		clk_sys_in = 1'b0;
		forever #50 clk_sys_in = ~clk_sys_in;
	end

	// ==========================================
	// shared helpers
	task automatic wrap_up();
		$display("checks %0d, mismatches %0d", num_checks, failures);
		if (failures == 0 && num_checks > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask
	task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
		num_checks++;
		if (got !== exp) begin
			failures++;
			$display("unexpected %s: expected %h, seen %h", what, exp, got);
		end
	endtask
	task automatic expire(input string what);
		check(what, 32'h1, 32'h0);
		wrap_up();
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge clk_sys_in);
		s_axi_awaddr_in <= {24'h000000, a};
		s_axi_wdata_in <= d;
		s_axi_awvalid_in <= 1'b1;
		s_axi_wvalid_in <= 1'b1;
		s_axi_bready_in <= 1'b1;
		do begin
			@(posedge clk_sys_in);
			n++;
			if (s_axi_awready_out === 1'b1) s_axi_awvalid_in <= 1'b0;
			if (s_axi_wready_out === 1'b1) s_axi_wvalid_in <= 1'b0;
		end while (s_axi_bvalid_out !== 1'b1 && n < 100);
		resp = s_axi_bresp_out;
		s_axi_bready_in <= 1'b0;
		if (n >= 100) expire("write answer");
	endtask
	task automatic rd(input logic [7:0] a);
		int n;
		n = 0;
		@(posedge clk_sys_in);
		s_axi_araddr_in <= {24'h000000, a};
		s_axi_arvalid_in <= 1'b1;
		s_axi_rready_in <= 1'b1;
		do begin
			@(posedge clk_sys_in);
			n++;
			if (s_axi_arready_out === 1'b1) s_axi_arvalid_in <= 1'b0;
		end while (s_axi_rvalid_out !== 1'b1 && n < 100);
		rd_data = s_axi_rdata_out;
		resp = s_axi_rresp_out;
		s_axi_rready_in <= 1'b0;
		if (n >= 100) expire("read answer");
	endtask
	function automatic logic pulse(input int s);
		case (s)
			0: return serial_transfer_clock_out;
			1: return io_shift_tick_out;
			2: return uart_tx_bit_tick_out;
			default: return uart_rx_bit_tick_out;
		endcase
	endfunction
	// cycles spanned by k pulses; the first two are skipped so a new setting settles
	task automatic span(input int s, input int k, input int exp, input string what);
		int n, n0, c;
		n = 0;
		n0 = 0;
		c = 0;
		repeat (k + 2) begin
			do begin
				@(negedge clk_sys_in);
				n++;
			end while (pulse(s) !== 1'b1 && n < 4000);
			c++;
			if (c == 2) n0 = n;
		end
		if (n >= 4000) expire(what);
		check(what, exp, n - n0);
	endtask

	// ==========================================
	// scenarios
	task automatic t_regs();
		logic [7:0] offs [5];
		logic [31:0] rst [5];
		offs = '{SCG_MODE0_OFF, SCG_CTRL_OFF, SCG_BAUD_OFF, SCG_FRAC_OFF, SCG_TCMP_OFF};
		rst = '{32'(SCG_MODE0_RST), 32'(SCG_CTRL_RST), 32'(SCG_BAUD_RST), 32'(SCG_FRAC_RST), 32'(SCG_TCMP_RST)};
		foreach (offs[i]) begin
			rd(offs[i]);
			check("reset value", rst[i], rd_data);
		end
		wr(SCG_MODE0_OFF, 32'hffffffff);
		rd(SCG_MODE0_OFF);
		check("mode0 width", 32'h0000000f, rd_data);
		wr(SCG_MODE0_OFF, 32'h00000000);
		wr(SCG_CTRL_OFF, 32'h00000002);
		rd(SCG_CTRL_OFF);
		check("edge select with pin output", 32'h00000000, rd_data);
		wr(8'h18, 32'h00000001);
		check("unmapped write response", 32'(SCG_RESP_SLVERR), 32'(resp));
		rd(8'h18);
		check("unmapped read response", 32'(SCG_RESP_SLVERR), 32'(resp));
		check("unmapped read data", 32'h00000000, rd_data);
		$display("test registers done");
	endtask
	task automatic t_io();
		wr(SCG_BAUD_OFF, 32'h00000002);
		check("pin drive enable", 32'h1, 32'(sclk_pin_oe_out));
		span(1, 4, 32, "driven shift spacing n2");
		wr(SCG_BAUD_OFF, 32'h00000000);
		span(1, 2, 128, "driven shift spacing n16");
		ext_half <= 8'h08;
		ext_run <= 1'b1;
		for (int e = 0; e < 2; e++) begin
			wr(SCG_CTRL_OFF, 32'(1 + 2 * e));
			check("pin drive enable", 32'h0, 32'(sclk_pin_oe_out));
			span(1, 3, 48, "input shift spacing");
			check("pin level at shift", 32'(e == 0), 32'(sclk_pin_in));
		end
		ext_run <= 1'b0;
		$display("test io modes done");
	endtask
	task automatic t_uart();
		int n;
		n = 0;
		wr(SCG_MODE0_OFF, {28'h0000000, SCG_SC_FSYS, 2'h1});
		span(0, 8, 8, "system clock ticks");
		span(2, 2, 32, "tx bit spacing");
		rx_restart_in <= 1'b1;
		@(posedge clk_sys_in);
		rx_restart_in <= 1'b0;
		span(3, 1, 16, "rx bit spacing");
		repeat (16) begin
			@(negedge clk_sys_in);
			if (uart_rx_sample_out === 1'b1) n++;
		end
		check("samples per bit", 32'h3, 32'(n));
		wr(SCG_MODE0_OFF, {28'h0000000, SCG_SC_BAUD, 2'h1});
		for (int c = 0; c < 4; c++) begin
			wr(SCG_BAUD_OFF, 32'(2 + 16 * c));
			span(0, 2, 8 << (2 * c), "prescaler tap spacing");
		end
		wr(SCG_BAUD_OFF, 32'h00000000);
		span(0, 1, 32, "divide by sixteen");
		wr(SCG_FRAC_OFF, 32'h0000000c);
		wr(SCG_BAUD_OFF, 32'h00000042);
		span(0, 16, 72, "fraction group length");
		wr(SCG_MODE0_OFF, {28'h0000000, SCG_SC_TIMER, 2'h1});
		for (int c = 1; c < 4; c += 2) begin
			wr(SCG_TCMP_OFF, 32'(c));
			span(0, 2, 8 * c, "timer tick spacing");
		end
		wr(SCG_MODE0_OFF, {28'h0000000, SCG_SC_PIN, 2'h1});
		ext_half <= 8'h03;
		ext_run <= 1'b1;
		span(0, 4, 24, "pin tick spacing");
		ext_run <= 1'b0;
		$display("test uart sources done");
	endtask

	initial begin
		nrst_in = 1'b0;
		s_axi_awvalid_in = 1'b0;
		s_axi_wvalid_in = 1'b0;
		s_axi_bready_in = 1'b0;
		s_axi_arvalid_in = 1'b0;
		s_axi_rready_in = 1'b0;
		s_axi_awaddr_in = 32'h00000000;
		s_axi_wdata_in = 32'h00000000;
		s_axi_araddr_in = 32'h00000000;
		s_axi_wstrb_in = 4'hf;
		rx_restart_in = 1'b0;
		ext_run = 1'b0;
		ext_half = 8'h03;
		failures = 0;
		num_checks = 0;
		repeat (6) @(posedge clk_sys_in);
		nrst_in <= 1'b1;
		@(posedge clk_sys_in);
		t_regs();
		t_io();
		t_uart();
		wrap_up();
	end
endmodule // scg_top_tb_top
